/* dv/sfr_flash_model.sv */
// Behavioural serial flash answering the host's read commands
`timescale 1ns/1ps
module sfr_flash_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  input wire logic qpi,
  input wire logic qe,
  input wire logic write_in_progress_flag,
  input wire logic [3:0] qdum,
  input wire logic [3:0] ddum,
  output logic [3:0] dev_o,
  output logic [3:0] dev_oe
);
  import sfr_pkg::*;
  int n = 0;
  int k;
  int j;
  logic [7:0] opc = 8'h00;
  logic [23:0] adr = 24'h000000;
  logic [3:0] mup = 4'h0;
  logic cont = 1'b0;
  logic md = 1'b0;
  logic [22:0] a;
  logic [7:0] b;
  logic hold;
  initial dev_o = 4'h5;
  initial dev_oe = 4'h0;
  // Pause exists only outside quad-instruction mode with quad enable clear
  assign hold = !qpi && !qe && !io_in[3];
  assign k = n - (cont ? 0 : 8);
  assign j = n - (qpi ? 8 + qdum : (cont || opc == SFR_OPC_DUAL_IO_READ) ?
    n - k + 12 + (ddum < 4 ? 4 : ddum) : 40);
  // Rising edges shift in command fields; select high abandons the frame
  always @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      n <= 0;
      if (md) cont <= (mup == SFR_CONT_READ_KEY);
      md <= 1'b0;
    end else if (!hold) begin
      n <= n + 1;
      if (qpi) begin
        if (n < 8) adr <= {adr[19:0], io_in};
      end else if (!cont && n < 8) opc <= {opc[6:0], io_in[0]};
      else if (cont || opc == SFR_OPC_DUAL_IO_READ) begin
        if (k < 12) adr <= {adr[21:0], io_in[1:0]};
        else if (k < 14) begin
          mup <= {mup[1:0], io_in[1:0]};
          md <= 1'b1;
        end
      end else if (k < 24) adr <= {adr[22:0], io_in[0]};
    end
  end
  // Falling edges drive data; released lines show a changing pattern
  always @(negedge sck or posedge cs_n) begin
    a = adr[22:0] + (qpi ? j / 2 : j / 4);
    b = a[7:0] + a[22:15] + 8'h3C;
    if (cs_n || hold || write_in_progress_flag || j < 0) begin
      dev_oe <= 4'h0;
      dev_o <= ~dev_o;
    end else if (qpi) begin
      dev_oe <= 4'hF;
      dev_o <= j[0] ? b[3:0] : b[7:4];
    end else begin
      dev_oe <= 4'h3;
      dev_o <= {~dev_o[3:2], b[7 - 2 * (j % 4) -: 2]};
    end
  end
endmodule

/* dv/sfr_host_assertions.sv */
// Port-level assertions for the serial flash read host
`timescale 1ns/1ps
module sfr_host_assertions #(
  parameter int unsigned HALF_DIV = 4
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire sfr_pkg::sfr_kind_t cmd_kind,
  input wire logic cfg_quad_enable_bit,
  input wire logic busy,
  input wire logic paused,
  input wire logic continuous_read_mode,
  input wire logic sck_o,
  input wire logic cs_n_o,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe
);
  import sfr_pkg::*;
  logic [7:0] hi_q;
  logic [7:0] gap_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Length of the current serial clock high phase
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) hi_q <= 8'h00;
    else hi_q <= sck_o ? hi_q + 8'h01 : 8'h00;
  end
  // Select idle time, saturating so a long idle never wraps
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) gap_q <= 8'hFF;
    else if (!cs_n_o) gap_q <= 8'h00;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  end
  AST_SCK_HIGH: assert property ($fell(sck_o) |-> hi_q == HALF_DIV)
    else $error("sck high phase length wrong");
  AST_CS_GAP: assert property ($fell(cs_n_o) |-> gap_q >= HALF_DIV + 1)
    else $error("select idle gap too short");
  AST_SCK_IDLE: assert property (cs_n_o |-> !sck_o)
    else $error("sck moves while deselected");
  AST_TAKE: assert property (cmd_valid && cmd_ready &&
    !(continuous_read_mode && cmd_kind != SFR_KIND_DUAL_IO) |=> busy && !cmd_ready && !cs_n_o)
    else $error("command take not answered");
  AST_PAUSE_FREEZE: assert property (paused && $past(paused) |-> !sck_o && $stable(sck_o))
    else $error("sck runs while paused");
  AST_PAUSE_LINE: assert property (paused && $past(paused) |-> io_oe[3] && !io_o[3])
    else $error("pause line not low");
  AST_RESUME: assert property ($fell(paused) |-> !sck_o ##1 io_o[3])
    else $error("resume not clean");
  AST_PAUSE_QE: assert property (cfg_quad_enable_bit && $past(cfg_quad_enable_bit) |-> !paused)
    else $error("pause with quad enable set");
endmodule
bind sfr_host sfr_host_assertions #(.HALF_DIV(HALF_DIV)) i_sfr_host_assertions (
  .core_clk, .rst_b, .cmd_valid, .cmd_ready, .cmd_kind, .cfg_quad_enable_bit, .busy,
  .paused, .continuous_read_mode, .sck_o, .cs_n_o, .io_o, .io_oe);

/* dv/testbench.sv */
// Self-checking bench for the serial flash read host
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s exp=%h got=%h", nm, ex, got); end end
module testbench;
  import sfr_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_abort = 1'b0;
  logic pause_req = 1'b0;
  logic qe = 1'b0;
  logic qpi = 1'b0;
  logic write_in_progress_flag = 1'b0;
  sfr_kind_t cmd_kind = SFR_KIND_DUAL_OUT;
  logic [7:0] cmd_opcode = 8'h00;
  logic [23:0] cmd_addr = 24'h000000;
  logic [7:0] cmd_mode = 8'h00;
  logic [15:0] cmd_len = 16'h0001;
  logic [3:0] qdum = 4'h6;
  logic [3:0] ddum = 4'h4;
  logic [7:0] rd_data;
  logic cmd_ready, rd_valid, busy, paused, cont, sck, cs_n;
  logic [3:0] io_o, io_oe, dev_o, dev_oe, io_w;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Wire level: host wins where it drives
  assign io_w = (io_oe & io_o) | (~io_oe & dev_o);
  sfr_host i_sfr_host (.core_clk, .rst_b, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_opcode,
    .cmd_addr, .cmd_mode, .cmd_len, .cmd_abort, .cfg_quad_dummy(qdum), .cfg_dual_dummy(ddum),
    .cfg_quad_enable_bit(qe), .pause_req, .rd_data, .rd_valid, .busy, .paused,
    .continuous_read_mode(cont), .sck_o(sck), .cs_n_o(cs_n), .io_o, .io_oe, .io_i(io_w));
  sfr_flash_model i_sfr_flash_model (.sck, .cs_n, .io_in(io_w), .qpi, .qe, .write_in_progress_flag, .qdum,
    .ddum, .dev_o, .dev_oe);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [7:0] mem(input logic [22:0] a);
    return a[7:0] + a[22:15] + 8'h3C;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end
  // One read, bytes checked as they arrive; pz 1 expects a pause, 2 a refused one
  task automatic run(input sfr_kind_t kd, input logic [7:0] op, input logic [23:0] ad,
      input logic [7:0] md, input int len, input bit good, input bit ab, input int pz,
      output int n);
    int t;
    qpi = (kd == SFR_KIND_QUAD_INSTR);
    cmd_kind = kd;
    cmd_opcode = op;
    cmd_addr = ad;
    cmd_mode = md;
    cmd_len = len[15:0];
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    t = 0;
    while ((busy === 1'b1 || rd_valid === 1'b1) && t < 9000) begin
      if (rd_valid === 1'b1) begin
        if (good) `CHK("rd_data", mem(ad[22:0] + n), rd_data)
        else `CHK("ignored", 1'b1, rd_data !== mem(ad[22:0] + n))
        n++;
        if (ab) cmd_abort = 1'b1;
      end
      if (pz != 0 && t == 100) pause_req = 1'b1;
      if (pz != 0 && t == 140) begin
        `CHK("paused", pz == 1, paused)
        `CHK("dev_oe", 4'h0, dev_oe)
        pause_req = 1'b0;
      end
      @(posedge core_clk);
      #1;
      t++;
    end
    cmd_abort = 1'b0;
    `CHK("cs_n", 1'b1, cs_n)
  endtask
  task automatic t_quad();
    logic [7:0] ops [5] = '{SFR_OPC_QUAD_INSTR_FAST_READ, SFR_OPC_QUAD_IO_READ,
      SFR_OPC_UNIQUE_IDENTIFIER_READ, SFR_OPC_DISCOVERABLE_PARAM_READ, SFR_OPC_INFO_ROW_READ};
    int n;
    for (int i = 0; i < 5; i++) begin
      qdum = (i == 4) ? 4'h9 : SFR_DUMMY_QUAD_DEFAULT;
      run(SFR_KIND_QUAD_INSTR, ops[i], (i == 4) ? 24'hFFFFFF : 24'h012340, 8'h00, 3, 1, 0, 0,
        n);
      `CHK("quad_cnt", 3, n)
    end
    $display("test quad done");
  endtask
  task automatic t_dio();
    int n;
    ddum = SFR_DUMMY_DUAL_DEFAULT;
    run(SFR_KIND_DUAL_IO, SFR_OPC_DUAL_IO_READ, 24'hABCDEF, 8'hA5, 4, 1, 0, 0, n);
    `CHK("cont_on", 1'b1, cont)
    ddum = 4'h6;
    run(SFR_KIND_DUAL_IO, SFR_OPC_DUAL_IO_READ, 24'h00FF0E, 8'h5A, 2, 1, 0, 0, n);
    `CHK("cont_off", 1'b0, cont)
    run(SFR_KIND_DUAL_IO, SFR_OPC_DUAL_IO_READ, 24'h000100, 8'h00, 1, 1, 0, 0, n);
    `CHK("dio_cnt", 1, n)
    $display("test dual io done");
  endtask
  task automatic t_dout();
    int n;
    run(SFR_KIND_DUAL_OUT, SFR_OPC_DUAL_OUTPUT_READ, 24'h3FFFFE, 8'h00, 3, 1, 0, 1, n);
    `CHK("dout_cnt", 3, n)
    qe = 1'b1;
    run(SFR_KIND_DUAL_OUT, SFR_OPC_DUAL_OUTPUT_READ, 24'h000040, 8'h00, 2, 1, 0, 2, n);
    qe = 1'b0;
    run(SFR_KIND_DUAL_OUT, SFR_OPC_DUAL_OUTPUT_READ, 24'h000080, 8'h00, 40, 1, 1, 0, n);
    `CHK("abort_cnt", 1'b1, n inside {[1:2]})
    $display("test dual out done");
  endtask
  task automatic t_wip();
    int n;
    write_in_progress_flag = 1'b1;
    run(SFR_KIND_QUAD_INSTR, SFR_OPC_QUAD_INSTR_FAST_READ, 24'h0000D5, 8'h00, 2, 0, 0, 0,
      n);
    write_in_progress_flag = 1'b0;
    $display("test busy device done");
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    t_quad();
    t_dio();
    t_dout();
    t_wip();
    report_and_stop();
  end
endmodule

/* rtl/sfr_host.sv */
// Host controller issuing quad-instruction, dual I/O and dual output reads
// Notes on behaviour
// R01: Quad-instruction fast read: opcode 2 clocks, address 6 clocks, four lines, then dummy.
// R02: Device drives quad read data on IO3..IO0 after dummy cycles.
// R03: Device streams bytes with incrementing address, wrapping to zero.
// R04: Host ends a read at a byte boundary by raising select.
// R05: Device ignores reads while its write-in-progress flag is set.
// R06: Same quad sequence serves quad I/O, unique ID, parameter and info row opcodes.
// R07: Quad dummy count is configurable, default six, same on both sides.
// R08: Host pauses by pulling the pause line low while serial clock is low.
// R09: Host resumes by raising the pause line while serial clock is low.
// R10: Device floats its output and ignores input while paused.
// R11: Pause is unavailable with quad enable set or in quad-instruction reads.
// R12: Dual I/O read: single-line opcode, 24 address bits two per clock, MSB on IO1.
// R13: Dual I/O read dummy count is configurable, default four.
// R14: Device drives dual I/O data two bits per clock, MSB on IO1.
// R15: Mode byte occupies first four cycles after address; only upper nibble matters.
// R16: Upper nibble 1010 enters continuous-read mode; next read skips the opcode.
// R17: Any other nibble leaves continuous-read mode; instruction mode unchanged.
// R18: Mode cycles count inside the dummy count.
// R19: Host floats the don't-care mode positions to avoid contention.
// R20: Dual output read: opcode, address and 8 dummy clocks all on IO0.
// R21: Dual output read data: first bit of pair on IO1, second on IO0.
// R22: Device ignores the top address bit.
// R23: Multi-line transfers send the most significant group first.
`timescale 1ns/1ps
module sfr_host #(
  parameter int unsigned HALF_DIV = 4,
  parameter int unsigned LEN_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // User command side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sfr_pkg::sfr_kind_t cmd_kind,
  input wire logic [7:0] cmd_opcode,
  input wire logic [23:0] cmd_addr,
  input wire logic [7:0] cmd_mode,
  input wire logic [LEN_W-1:0] cmd_len,
  input wire logic cmd_abort,
  input wire logic [3:0] cfg_quad_dummy,
  input wire logic [3:0] cfg_dual_dummy,
  input wire logic cfg_quad_enable_bit,
  input wire logic pause_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output logic paused,
  output logic continuous_read_mode,
  // Flash pins
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe,
  input wire logic [3:0] io_i
);
  import sfr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_END
  } sfr_state_t;

  localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

  sfr_state_t state_q;
  sfr_kind_t kind_q;
  logic [31:0] tx_q;
  logic [2:0] lines_q;
  logic [4:0] cyc_q;
  logic [7:0] mode_q;
  logic [3:0] dual_dummy_q;
  logic [3:0] quad_dummy_q;
  logic [LEN_W-1:0] len_q;
  logic [2:0] bitcnt_q;
  logic [7:0] rx_q;
  logic [7:0] div_q;
  logic [23:0] addr_q;
  logic abort_q;
  logic [3:0] io_sync;
  logic wrap;
  logic running;
  logic fall_tick;
  logic take;
  logic pause_ok;
  logic [7:0] rx_next;
  logic [4:0] dual_rest;

  // Next group of bits to put on the lines, top bits first
  function automatic logic [3:0] tx_slice(input logic [31:0] tx, input logic [2:0] lines);
    case (lines)
      SFR_LINES_4: tx_slice = tx[31:28];
      SFR_LINES_2: tx_slice = {2'h0, tx[31:30]};
      default: tx_slice = {3'h0, tx[31]};
    endcase
  endfunction

  // Drop the group just sent
  function automatic logic [31:0] tx_shift(input logic [31:0] tx, input logic [2:0] lines);
    case (lines)
      SFR_LINES_4: tx_shift = {tx[27:0], 4'h0};
      SFR_LINES_2: tx_shift = {tx[29:0], 2'h0};
      default: tx_shift = {tx[30:0], 1'h0};
    endcase
  endfunction

  // Enables for the lines in use
  function automatic logic [3:0] line_mask(input logic [2:0] lines);
    case (lines)
      SFR_LINES_4: line_mask = 4'hF;
      SFR_LINES_2: line_mask = 4'h3;
      default: line_mask = 4'h1;
    endcase
  endfunction

  // Pins from the device pass two flops before use
  sfr_sync #(
    .WIDTH(4)
  ) u_io_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(io_i),
    .sync_out(io_sync)
  );

  assign wrap = (div_q == DIV_LAST);
  assign running = (state_q != ST_IDLE) && (state_q != ST_END) && !paused;
  assign fall_tick = running && wrap && sck_o;
  // A pending continuous-read mode admits only another dual I/O read
  assign take = cmd_valid && cmd_ready &&
                !(continuous_read_mode && (cmd_kind != SFR_KIND_DUAL_IO));
  // Quad-instruction reads use IO3 as data, so it cannot double as pause
  assign pause_ok = (kind_q != SFR_KIND_QUAD_INSTR) && !cfg_quad_enable_bit && running; // R11
  assign dual_rest = 5'(dual_dummy_q) - SFR_CYC_MODE_DUAL; // R18
  // Newest data group merged into the byte being assembled, MSB group first
  assign rx_next = (lines_q == SFR_LINES_4) ? {rx_q[3:0], io_sync} :
                   {rx_q[5:0], io_sync[1], io_sync[0]}; // R14 R21 R23

  // Divider for the serial clock; held at zero while paused or idle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 8'h00;
    end else if (state_q == ST_IDLE || paused || wrap) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Serial clock, idles low; no edges in the end phase
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_o <= 1'b0;
    end else if (running && wrap) begin
      sck_o <= !sck_o;
    end else if (!running && !paused) begin
      sck_o <= 1'b0;
    end
  end

  // Pause enters and leaves only while the serial clock is low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      paused <= 1'b0;
    end else if (!paused && pause_req && pause_ok && !sck_o && !wrap) begin
      paused <= 1'b1; // R08
    end else if (paused && !pause_req) begin
      paused <= 1'b0; // R09
    end
  end

  // Abort request held until the host returns to idle; set beats clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      abort_q <= 1'b0;
    end else if (cmd_abort && busy) begin
      abort_q <= 1'b1;
    end else if (state_q == ST_IDLE) begin
      abort_q <= 1'b0;
    end
  end

  // Sequencer: each phase from opcode to data advances on the falling serial clock
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      kind_q <= SFR_KIND_QUAD_INSTR;
      tx_q <= 32'h0000_0000;
      lines_q <= SFR_LINES_1;
      cyc_q <= 5'h00;
      mode_q <= 8'h00;
      dual_dummy_q <= SFR_DUMMY_DUAL_DEFAULT;
      quad_dummy_q <= SFR_DUMMY_QUAD_DEFAULT;
      len_q <= '0;
      bitcnt_q <= 3'h0;
      rx_q <= 8'h00;
      continuous_read_mode <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            kind_q <= cmd_kind;
            mode_q <= cmd_mode;
            len_q <= (cmd_len == '0) ? LEN_W'(1) : cmd_len;
            quad_dummy_q <= cfg_quad_dummy;
            // Mode cycles always fit inside the dual I/O dummy period
            dual_dummy_q <= (cfg_dual_dummy < SFR_DUMMY_DUAL_DEFAULT) ?
                            SFR_DUMMY_DUAL_DEFAULT : cfg_dual_dummy;
            bitcnt_q <= 3'h0;
            if (cmd_kind == SFR_KIND_QUAD_INSTR) begin
              state_q <= ST_OPC;
              tx_q <= {cmd_opcode, 24'h00_0000}; // R06
              cyc_q <= SFR_CYC_OPC_QUAD; // R01
              lines_q <= SFR_LINES_4;
            end else if (cmd_kind == SFR_KIND_DUAL_IO && continuous_read_mode) begin
              state_q <= ST_ADDR; // R16
              tx_q <= {cmd_addr, 8'h00};
              cyc_q <= SFR_CYC_ADDR_DUAL;
              lines_q <= SFR_LINES_2;
            end else begin
              state_q <= ST_OPC;
              tx_q <= {(cmd_kind == SFR_KIND_DUAL_IO) ? SFR_OPC_DUAL_IO_READ :
                       SFR_OPC_DUAL_OUTPUT_READ, 24'h00_0000}; // R12 R20
              cyc_q <= SFR_CYC_OPC_SINGLE;
              lines_q <= SFR_LINES_1;
            end
          end
        end
        ST_OPC: begin
          if (fall_tick) begin
            if (cyc_q == 5'h01) begin
              state_q <= ST_ADDR;
              tx_q <= {addr_q, 8'h00};
              case (kind_q)
                SFR_KIND_QUAD_INSTR: begin
                  cyc_q <= SFR_CYC_ADDR_QUAD; // R01
                  lines_q <= SFR_LINES_4;
                end
                SFR_KIND_DUAL_IO: begin
                  cyc_q <= SFR_CYC_ADDR_DUAL; // R12
                  lines_q <= SFR_LINES_2;
                end
                default: begin
                  cyc_q <= SFR_CYC_ADDR_SINGLE; // R20
                  lines_q <= SFR_LINES_1;
                end
              endcase
            end else begin
              tx_q <= tx_shift(tx_q, lines_q); // R23
              cyc_q <= cyc_q - 5'h01;
            end
          end
        end
        ST_ADDR: begin
          if (fall_tick) begin
            if (cyc_q == 5'h01) begin
              case (kind_q)
                SFR_KIND_QUAD_INSTR: begin
                  state_q <= (quad_dummy_q == 4'h0) ? ST_DATA : ST_DUMMY;
                  cyc_q <= 5'(quad_dummy_q); // R07
                  lines_q <= SFR_LINES_4;
                end
                SFR_KIND_DUAL_IO: begin
                  state_q <= ST_MODE; // R15
                  tx_q <= {mode_q, 24'h00_0000};
                  cyc_q <= SFR_CYC_MODE_DUAL;
                  lines_q <= SFR_LINES_2;
                end
                default: begin
                  state_q <= ST_DUMMY;
                  cyc_q <= SFR_CYC_DUMMY_DUAL_OUT; // R20
                  lines_q <= SFR_LINES_2;
                end
              endcase
            end else begin
              tx_q <= tx_shift(tx_q, lines_q); // R23
              cyc_q <= cyc_q - 5'h01;
            end
          end
        end
        ST_MODE: begin
          if (fall_tick) begin
            if (cyc_q == 5'h01) begin
              continuous_read_mode <= (mode_q[7:4] == SFR_CONT_READ_KEY); // R16 R17
              state_q <= (dual_rest == 5'h00) ? ST_DATA : ST_DUMMY; // R13 R18
              cyc_q <= dual_rest;
            end else begin
              tx_q <= tx_shift(tx_q, lines_q);
              cyc_q <= cyc_q - 5'h01;
            end
          end
        end
        ST_DUMMY: begin
          if (fall_tick) begin
            if (cyc_q == 5'h01) begin
              state_q <= ST_DATA;
            end
            cyc_q <= cyc_q - 5'h01;
          end
        end
        ST_DATA: begin
          if (fall_tick) begin
            rx_q <= rx_next;
            bitcnt_q <= bitcnt_q + lines_q;
            if (3'(bitcnt_q + lines_q) == 3'h0) begin
              len_q <= len_q - LEN_W'(1);
              if (len_q == LEN_W'(1) || abort_q) begin
                state_q <= ST_END; // R04
              end
            end
          end
        end
        ST_END: begin
          if (wrap) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Address is latched at command time and reloaded after the opcode
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= 24'h00_0000;
    end else if (take) begin
      addr_q <= cmd_addr;
    end
  end

  // Received byte handed out as a one-cycle pulse
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (state_q == ST_DATA && fall_tick && 3'(bitcnt_q + lines_q) == 3'h0) begin
        rd_data <= rx_next;
        rd_valid <= 1'b1;
      end
    end
  end

  // Select, ready and busy; select rises only with the clock low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_n_o <= 1'b1;
      cmd_ready <= 1'b0;
      busy <= 1'b0;
    end else begin
      cs_n_o <= (state_q == ST_IDLE && !take) || state_q == ST_END; // R04
      cmd_ready <= (state_q == ST_IDLE) && !take;
      busy <= (state_q != ST_IDLE) || take;
    end
  end

  // Drive the data lines one core cycle after each falling edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_o <= 4'h0;
      io_oe <= 4'h0;
    end else begin
      io_o <= tx_slice(tx_q, lines_q); // R12 R23
      case (state_q)
        ST_OPC, ST_ADDR: io_oe <= line_mask(lines_q);
        // Low mode nibble positions float so the device may drive early
        ST_MODE: io_oe <= (cyc_q > SFR_CYC_MODE_HIZ) ? line_mask(lines_q) : 4'h0; // R19
        default: io_oe <= 4'h0;
      endcase
      // Outside quad reads IO3 serves as the active-low pause line
      if (state_q != ST_IDLE && kind_q != SFR_KIND_QUAD_INSTR) begin
        io_o[3] <= !paused; // R08 R09
        io_oe[3] <= 1'b1;
      end
    end
  end

endmodule

/* rtl/sfr_pkg.sv */
// Constants and types shared by the serial flash read-path host controller
package sfr_pkg;

  // Read command families that the host can issue
  typedef enum logic [1:0] {
    SFR_KIND_QUAD_INSTR,
    SFR_KIND_DUAL_IO,
    SFR_KIND_DUAL_OUT
  } sfr_kind_t;

  // Opcodes
  localparam logic [7:0] SFR_OPC_QUAD_INSTR_FAST_READ = 8'h0B;
  localparam logic [7:0] SFR_OPC_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] SFR_OPC_UNIQUE_IDENTIFIER_READ = 8'h4B;
  localparam logic [7:0] SFR_OPC_DISCOVERABLE_PARAM_READ = 8'h5A;
  localparam logic [7:0] SFR_OPC_INFO_ROW_READ = 8'h68;
  localparam logic [7:0] SFR_OPC_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] SFR_OPC_DUAL_OUTPUT_READ = 8'h3B;

  // Serial clock cycles per phase
  localparam logic [4:0] SFR_CYC_OPC_QUAD = 5'h02;
  localparam logic [4:0] SFR_CYC_OPC_SINGLE = 5'h08;
  localparam logic [4:0] SFR_CYC_ADDR_QUAD = 5'h06;
  localparam logic [4:0] SFR_CYC_ADDR_DUAL = 5'h0C;
  localparam logic [4:0] SFR_CYC_ADDR_SINGLE = 5'h18;
  localparam logic [4:0] SFR_CYC_MODE_DUAL = 5'h04;
  localparam logic [4:0] SFR_CYC_MODE_HIZ = 5'h02;
  localparam logic [4:0] SFR_CYC_DUMMY_DUAL_OUT = 5'h08;

  // Default dummy counts
  localparam logic [3:0] SFR_DUMMY_QUAD_DEFAULT = 4'h6;
  localparam logic [3:0] SFR_DUMMY_DUAL_DEFAULT = 4'h4;

  // Upper mode nibble that keeps continuous-read mode
  localparam logic [3:0] SFR_CONT_READ_KEY = 4'hA;

  // Lines per serial clock
  localparam logic [2:0] SFR_LINES_1 = 3'h1;
  localparam logic [2:0] SFR_LINES_2 = 3'h2;
  localparam logic [2:0] SFR_LINES_4 = 3'h4;

endpackage

/* rtl/sfr_sync.sv */
// Two flip-flop synchroniser for the IO pins
`timescale 1ns/1ps
module sfr_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
